// file: verilog/spm_map.svh
// Register offsets, field positions and reset values of the pin mux block.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one word per register.
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SPM_OFF_GP_EN   5'h00
`define SPM_OFF_GP_DIR  5'h04
`define SPM_OFF_GP_OUT  5'h08
`define SPM_OFF_GP_IN   5'h0c
`define SPM_OFF_STRAP   5'h10

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define SPM_GP_EN_RST   16'h0000
`define SPM_GP_DIR_RST  16'h0000
`define SPM_GP_OUT_RST  16'h0000
`define SPM_GP_DIV4     1
`define SPM_GP_DIV6     2
`define SPM_GP_SP2CK    8
`define SPM_GP_UP_LO    9
`define SPM_GP_UP_HI    15
`define SPM_ST_WIDE     0
`define SPM_ST_ATM      1
`define SPM_ST_PCI      2
`define SPM_RESP_OKAY   2'h0
`define SPM_RESP_SLVERR 2'h2

`endif

// file: verilog/spm_pkg.sv
// Types shared by the pin mux block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package spm_pkg;
	typedef logic [31:0] spm_word_t;
	typedef logic [15:0] spm_gpio_t;
	typedef logic [4:0]  spm_addr_t;

	// Strap levels caught at reset release
	typedef struct packed {
		logic pci;
		logic atm;
		logic wide;
	} spm_strap_s;

	typedef enum logic {
		spm_rd_idle,
		spm_rd_busy
	} spm_rd_e;
endpackage : spm_pkg

`default_nettype wire

// file: verilog/spm_reg_if.sv
// Simple register access carrier between bus slave and register file.
// Assumes one access per cycle, read data valid in the cycle of rd.
`default_nettype none

interface spm_reg_if;
	logic               wr;
	logic               rd;
	spm_pkg::spm_addr_t addr;
	spm_pkg::spm_word_t wdata;
	logic [3:0]         wstrb;
	spm_pkg::spm_word_t rdata;
	logic               err;

	modport bus  (output wr, rd, addr, wdata, wstrb, input rdata, err);
	modport regs (input wr, rd, addr, wdata, wstrb, output rdata, err);
endinterface : spm_reg_if

`default_nettype wire

// file: verilog/spm_strap_latch.sv
// Catches the strap levels once, at the first edge after reset release.
// Assumes strap pins are steady around reset release.
`default_nettype none

module spm_strap_latch (
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire logic           host_width_strap_pin,
	input  wire logic           atm_strap_pin,
	input  wire logic           pci_strap_pin,
	output var  spm_pkg::spm_strap_s strap,
	output logic                captured
);
	// Defaults until capture: narrow host port, serial port, no PCI
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strap    <= '0;
			captured <= 1'b0;
		end else if (!captured) begin
			strap.wide <= host_width_strap_pin;
			strap.atm  <= atm_strap_pin;
			strap.pci  <= pci_strap_pin;
			captured   <= 1'b1;
		end
	end

	property p_hold;
		@(posedge clk) disable iff (!rst_n)
		captured |=> $stable(strap) && captured;
	endproperty
	chk_strap_held: assert property (p_hold) else $error("strap changed after capture");
endmodule : spm_strap_latch

`default_nettype wire

// file: verilog/spm_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into register accesses.
// Assumes the register file answers in the cycle of the access.
`default_nettype none
`include "spm_map.svh"

module spm_axil_slave (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [4:0]   awaddr,
	input  wire logic         awvalid,
	output logic              awready,
	input  wire logic [31:0]  wdata,
	input  wire logic [3:0]   wstrb,
	input  wire logic         wvalid,
	output logic              wready,
	output logic [1:0]        bresp,
	output logic              bvalid,
	input  wire logic         bready,
	input  wire logic [4:0]   araddr,
	input  wire logic         arvalid,
	output logic              arready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	output logic              rvalid,
	input  wire logic         rready,
	spm_reg_if.bus            rif
);
	spm_pkg::spm_addr_t aw_addr_ff;
	spm_pkg::spm_addr_t ar_addr_ff;
	spm_pkg::spm_word_t w_data_ff;
	logic [3:0]         w_strb_ff;
	spm_pkg::spm_rd_e   rd_st_ff;

	// Reads take the port first; a waiting write slips one cycle
	assign rif.rd    = (rd_st_ff == spm_pkg::spm_rd_busy);
	assign rif.wr    = !awready && !wready && !bvalid && !rif.rd;
	assign rif.addr  = rif.rd ? ar_addr_ff : aw_addr_ff;
	assign rif.wdata = w_data_ff;
	assign rif.wstrb = w_strb_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			awready    <= 1'b1;
			aw_addr_ff <= 5'h00;
		end else if (awvalid && awready) begin
			awready    <= 1'b0;
			aw_addr_ff <= {awaddr[4:2], 2'h0};
		end else if (bvalid && bready) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wready    <= 1'b1;
			w_data_ff <= 32'h0000_0000;
			w_strb_ff <= 4'h0;
		end else if (wvalid && wready) begin
			wready    <= 1'b0;
			w_data_ff <= wdata;
			w_strb_ff <= wstrb;
		end else if (bvalid && bready) begin
			wready <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp  <= `SPM_RESP_OKAY;
		end else if (rif.wr) begin
			bvalid <= 1'b1;
			bresp  <= rif.err ? `SPM_RESP_SLVERR : `SPM_RESP_OKAY;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arready    <= 1'b1;
			ar_addr_ff <= 5'h00;
			rd_st_ff   <= spm_pkg::spm_rd_idle;
			rvalid     <= 1'b0;
			rdata      <= 32'h0000_0000;
			rresp      <= `SPM_RESP_OKAY;
		end else begin
			case (rd_st_ff)
				spm_pkg::spm_rd_idle: begin
					if (arvalid && arready) begin
						arready    <= 1'b0;
						ar_addr_ff <= {araddr[4:2], 2'h0};
						rd_st_ff   <= spm_pkg::spm_rd_busy;
					end else if (rvalid && rready) begin
						rvalid  <= 1'b0;
						arready <= 1'b1;
					end
				end
				spm_pkg::spm_rd_busy: begin
					rvalid   <= 1'b1;
					rdata    <= rif.rdata;
					rresp    <= rif.err ? `SPM_RESP_SLVERR : `SPM_RESP_OKAY;
					rd_st_ff <= spm_pkg::spm_rd_idle;
				end
				default: rd_st_ff <= spm_pkg::spm_rd_idle;
			endcase
		end
	end
endmodule : spm_axil_slave

`default_nettype wire

// file: verilog/spm_pin_mux.sv
// Pin-function mux: strap-fixed host/PCI and serial/ATM groups, and
// software-steered clock-output pins and GPIO. Registers over AXI4-Lite.
// Assumes pins and peripherals are synchronous to clk; pads resolve oe.
//
// Function
// - Narrow strap: 16-bit host, upper pins tristated
// - Wide strap: host uses all 32 pins
// - Strap-chosen pins fixed until next reset
// - One owner per strap-chosen group
// - Software pins switch any time by writes
// - Reset: clock outputs, serial clock, enables cleared
// - Enable bit hands pin to GPIO
// - Direction 0 input, 1 driven output
// - Upper GPIO only with PCI strap low
// - Default: shared pins serve serial port one
// - ATM takes pins only with strap high
// - ATM strap high: serial-only pins tristated
// - Host port default; PCI only if strapped
// - Disabled function's own pins tristated
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`default_nettype none
`include "spm_map.svh"

module spm_pin_mux (
	input  wire logic         clk,
	input  wire logic         rst_n,
	// AXI4-Lite register port
	input  wire logic [4:0]   s_awaddr,
	input  wire logic         s_awvalid,
	output logic              s_awready,
	input  wire logic [31:0]  s_wdata,
	input  wire logic [3:0]   s_wstrb,
	input  wire logic         s_wvalid,
	output logic              s_wready,
	output logic [1:0]        s_bresp,
	output logic              s_bvalid,
	input  wire logic         s_bready,
	input  wire logic [4:0]   s_araddr,
	input  wire logic         s_arvalid,
	output logic              s_arready,
	output logic [31:0]       s_rdata,
	output logic [1:0]        s_rresp,
	output logic              s_rvalid,
	input  wire logic         s_rready,
	// Strap pins
	input  wire logic         host_width_strap_pin,
	input  wire logic         atm_strap_pin,
	input  wire logic         pci_strap_pin,
	output logic              host_port_width_select,
	// Host data bus pins, shared with PCI address/data
	input  wire logic [31:0]  host_data_bus_i,
	output logic [31:0]       host_data_bus_o,
	output logic [31:0]       host_data_bus_oe,
	input  wire logic [31:0]  hpi_dout,
	input  wire logic         hpi_doe,
	output logic [31:0]       hpi_din,
	input  wire logic [31:0]  pci_ad_out,
	input  wire logic         pci_ad_oe,
	output logic [31:0]       pci_ad_in,
	// Serial port one / ATM shared pins and standalone pins
	input  wire logic [3:0]   shared_pin_i,
	output logic [3:0]        shared_pin_o,
	output logic [3:0]        shared_pin_oe,
	input  wire logic [3:0]   sp1_out,
	input  wire logic [3:0]   sp1_oe,
	output logic [3:0]        sp1_in,
	input  wire logic [3:0]   atm_out,
	input  wire logic [3:0]   atm_oe,
	output logic [3:0]        atm_in,
	output logic [1:0]        sp1_solo_o,
	output logic [1:0]        sp1_solo_oe,
	input  wire logic [1:0]   sp1_solo_out,
	output logic [1:0]        atm_solo_o,
	output logic [1:0]        atm_solo_oe,
	input  wire logic [1:0]   atm_solo_out,
	output logic [1:0]        pci_solo_o,
	output logic [1:0]        pci_solo_oe,
	input  wire logic [1:0]   pci_solo_out,
	// GPIO pins and their default functions
	input  wire logic [15:0]  gpio_pin_i,
	output logic [15:0]       gpio_pin_o,
	output logic [15:0]       gpio_pin_oe,
	input  wire logic         cpu_div4_clock_output,
	input  wire logic         cpu_div6_clock_output,
	output logic              serial_port2_ext_clock_input,
	input  wire logic [15:9]  pci_gp_out,
	input  wire logic [15:9]  pci_gp_oe,
	output logic [15:9]       pci_gp_in
);
	spm_reg_if           rif ();
	spm_pkg::spm_strap_s strap;
	logic                captured;
	spm_pkg::spm_gpio_t  gp_en_ff;
	spm_pkg::spm_gpio_t  gp_dir_ff;
	spm_pkg::spm_gpio_t  gp_out_ff;
	spm_pkg::spm_gpio_t  gp_in_ff;
	spm_pkg::spm_gpio_t  gp_own;
	spm_pkg::spm_gpio_t  nxt_gp_o;
	spm_pkg::spm_gpio_t  nxt_gp_oe;

	// Lanes merge a byte-enabled write into a 16-bit register
	function automatic spm_pkg::spm_gpio_t merge16(input spm_pkg::spm_gpio_t old,
		input spm_pkg::spm_word_t wd, input logic [3:0] be);
		merge16 = old;
		if (be[0]) merge16[7:0]  = wd[7:0];
		if (be[1]) merge16[15:8] = wd[15:8];
	endfunction : merge16

	// ----------------------------------------------------------------
	// Bus slave and strap capture
	// ----------------------------------------------------------------
	spm_axil_slave u_bus (
		.clk     (clk),
		.rst_n   (rst_n),
		.awaddr  (s_awaddr),
		.awvalid (s_awvalid),
		.awready (s_awready),
		.wdata   (s_wdata),
		.wstrb   (s_wstrb),
		.wvalid  (s_wvalid),
		.wready  (s_wready),
		.bresp   (s_bresp),
		.bvalid  (s_bvalid),
		.bready  (s_bready),
		.araddr  (s_araddr),
		.arvalid (s_arvalid),
		.arready (s_arready),
		.rdata   (s_rdata),
		.rresp   (s_rresp),
		.rvalid  (s_rvalid),
		.rready  (s_rready),
		.rif     (rif)
	);

	spm_strap_latch u_strap (
		.clk                  (clk),
		.rst_n                (rst_n),
		.host_width_strap_pin (host_width_strap_pin),
		.atm_strap_pin        (atm_strap_pin),
		.pci_strap_pin        (pci_strap_pin),
		.strap                (strap),
		.captured             (captured)
	);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_comb begin
		rif.err   = 1'b0;
		rif.rdata = 32'h0000_0000;
		case (rif.addr)
			`SPM_OFF_GP_EN:  rif.rdata = {16'h0000, gp_en_ff};
			`SPM_OFF_GP_DIR: rif.rdata = {16'h0000, gp_dir_ff};
			`SPM_OFF_GP_OUT: rif.rdata = {16'h0000, gp_out_ff};
			`SPM_OFF_GP_IN:  rif.rdata = {16'h0000, gp_in_ff};
			`SPM_OFF_STRAP:  rif.rdata = {29'h0000_0000, strap};
			default:         rif.err   = 1'b1;
		endcase
	end

	// Writable at any time; no reset needed to switch a pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gp_en_ff  <= `SPM_GP_EN_RST;
			gp_dir_ff <= `SPM_GP_DIR_RST;
			gp_out_ff <= `SPM_GP_OUT_RST;
		end else if (rif.wr) begin
			case (rif.addr)
				`SPM_OFF_GP_EN:  gp_en_ff  <= merge16(gp_en_ff, rif.wdata, rif.wstrb);
				`SPM_OFF_GP_DIR: gp_dir_ff <= merge16(gp_dir_ff, rif.wdata, rif.wstrb);
				`SPM_OFF_GP_OUT: gp_out_ff <= merge16(gp_out_ff, rif.wdata, rif.wstrb);
				default:         gp_en_ff  <= gp_en_ff;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Host port / PCI data pins
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			host_data_bus_o        <= 32'h0000_0000;
			host_data_bus_oe       <= 32'h0000_0000;
			hpi_din                <= 32'h0000_0000;
			pci_ad_in              <= 32'h0000_0000;
			host_port_width_select <= 1'b0;
		end else begin
			host_port_width_select <= strap.wide;
			if (strap.pci) begin
				host_data_bus_o  <= pci_ad_out;
				host_data_bus_oe <= {32{pci_ad_oe}};
				pci_ad_in        <= host_data_bus_i;
				hpi_din          <= 32'h0000_0000;
			end else if (strap.wide) begin
				host_data_bus_o  <= hpi_dout;
				host_data_bus_oe <= {32{hpi_doe}};
				hpi_din          <= host_data_bus_i;
				pci_ad_in        <= 32'h0000_0000;
			end else begin
				// Upper half is reserved and left floating
				host_data_bus_o  <= {16'h0000, hpi_dout[15:0]};
				host_data_bus_oe <= {16'h0000, {16{hpi_doe}}};
				hpi_din          <= {16'h0000, host_data_bus_i[15:0]};
				pci_ad_in        <= 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pci_solo_o  <= 2'h0;
			pci_solo_oe <= 2'h0;
		end else begin
			pci_solo_o  <= strap.pci ? pci_solo_out : 2'h0;
			pci_solo_oe <= strap.pci ? 2'h3 : 2'h0;
		end
	end

	// ----------------------------------------------------------------
	// Serial port one / ATM pins
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shared_pin_o  <= 4'h0;
			shared_pin_oe <= 4'h0;
			sp1_in        <= 4'h0;
			atm_in        <= 4'h0;
		end else if (strap.atm) begin
			shared_pin_o  <= atm_out;
			shared_pin_oe <= atm_oe;
			atm_in        <= shared_pin_i;
			sp1_in        <= 4'h0;
		end else begin
			shared_pin_o  <= sp1_out;
			shared_pin_oe <= sp1_oe;
			sp1_in        <= shared_pin_i;
			atm_in        <= 4'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sp1_solo_o  <= 2'h0;
			sp1_solo_oe <= 2'h0;
			atm_solo_o  <= 2'h0;
			atm_solo_oe <= 2'h0;
		end else begin
			sp1_solo_o  <= strap.atm ? 2'h0 : sp1_solo_out;
			sp1_solo_oe <= strap.atm ? 2'h0 : 2'h3;
			atm_solo_o  <= strap.atm ? atm_solo_out : 2'h0;
			atm_solo_oe <= strap.atm ? 2'h3 : 2'h0;
		end
	end

	// ----------------------------------------------------------------
	// GPIO pins
	// ----------------------------------------------------------------
	always_comb begin
		gp_own = gp_en_ff;
		if (strap.pci) begin
			gp_own[`SPM_GP_UP_HI:`SPM_GP_UP_LO] = 7'h00;
		end
		nxt_gp_o  = 16'h0000;
		nxt_gp_oe = 16'h0000;
		// Default functions first; direction bits unused here
		nxt_gp_o[`SPM_GP_DIV4]  = cpu_div4_clock_output;
		nxt_gp_oe[`SPM_GP_DIV4] = 1'b1;
		nxt_gp_o[`SPM_GP_DIV6]  = cpu_div6_clock_output;
		nxt_gp_oe[`SPM_GP_DIV6] = 1'b1;
		if (strap.pci) begin
			nxt_gp_o[`SPM_GP_UP_HI:`SPM_GP_UP_LO]  = pci_gp_out;
			nxt_gp_oe[`SPM_GP_UP_HI:`SPM_GP_UP_LO] = pci_gp_oe;
		end
		for (int i = 0; i < 16; i++) begin
			if (gp_own[i]) begin
				nxt_gp_o[i]  = gp_out_ff[i];
				nxt_gp_oe[i] = gp_dir_ff[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gpio_pin_o                   <= 16'h0000;
			gpio_pin_oe                  <= 16'h0000;
			gp_in_ff                     <= 16'h0000;
			serial_port2_ext_clock_input <= 1'b0;
			pci_gp_in                    <= 7'h00;
		end else begin
			gpio_pin_o  <= nxt_gp_o;
			gpio_pin_oe <= nxt_gp_oe;
			gp_in_ff    <= gpio_pin_i & gp_own;
			serial_port2_ext_clock_input <= gp_own[`SPM_GP_SP2CK] ? 1'b0
				: gpio_pin_i[`SPM_GP_SP2CK];
			pci_gp_in   <= strap.pci ? gpio_pin_i[`SPM_GP_UP_HI:`SPM_GP_UP_LO] : 7'h00;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_narrow_upper_hiz: assert property (@(posedge clk) disable iff (!rst_n)
		!strap.pci && !strap.wide |=> host_data_bus_oe[31:16] == 16'h0000)
		else $error("upper host pins driven in narrow mode");

	chk_wide_all_pins: assert property (@(posedge clk) disable iff (!rst_n)
		!strap.pci && strap.wide && hpi_doe |=> host_data_bus_oe == 32'hffff_ffff)
		else $error("wide host port not driving all pins");

	chk_host_pci_owner: assert property (@(posedge clk) disable iff (!rst_n)
		strap.pci |=> host_data_bus_o == $past(pci_ad_out) && hpi_din == 32'h0000_0000)
		else $error("pci strap set but host port owns pins");

	chk_shared_one_owner: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> ($past(strap.atm) ? sp1_in : atm_in) == 4'h0)
		else $error("both peripherals see shared pins");

	chk_serial_default: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n && !strap.atm
		|=> shared_pin_o == $past(sp1_out) && shared_pin_oe == $past(sp1_oe))
		else $error("shared pins not serving serial port");

	chk_atm_solo_state: assert property (@(posedge clk) disable iff (!rst_n)
		strap.atm |=> sp1_solo_oe == 2'h0 && atm_solo_oe == 2'h3)
		else $error("serial-only pins driven with atm strap");

	chk_solo_hiz: assert property (@(posedge clk) disable iff (!rst_n)
		!strap.atm && !strap.pci |=> atm_solo_oe == 2'h0 && pci_solo_oe == 2'h0)
		else $error("disabled function pins driven");

	chk_gp_default_clk: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n && !gp_en_ff[`SPM_GP_DIV4] |=> gpio_pin_oe[`SPM_GP_DIV4]
			&& gpio_pin_o[`SPM_GP_DIV4] == $past(cpu_div4_clock_output))
		else $error("div4 pin lost default function");

	chk_gp_direction: assert property (@(posedge clk) disable iff (!rst_n)
		gp_own[`SPM_GP_DIV4] |=> gpio_pin_oe[`SPM_GP_DIV4] == $past(gp_dir_ff[`SPM_GP_DIV4]))
		else $error("gpio direction not applied");

	chk_upper_pci_lock: assert property (@(posedge clk) disable iff (!rst_n)
		strap.pci |=> gpio_pin_oe[15:9] == $past(pci_gp_oe))
		else $error("upper gpio taken while pci strapped");

	chk_gp_reset_clear: assert property (@(posedge clk)
		$rose(rst_n) |-> gp_en_ff == 16'h0000 && gp_dir_ff == 16'h0000)
		else $error("gpio enables not clear after reset");

	chk_en_write_takes: assert property (@(posedge clk) disable iff (!rst_n)
		rif.wr && rif.addr == `SPM_OFF_GP_EN && rif.wstrb == 4'hf
		|=> gp_en_ff == $past(rif.wdata[15:0]))
		else $error("enable write not applied");

	chk_width_follows: assert property (@(posedge clk) disable iff (!rst_n)
		captured |=> host_port_width_select == $past(strap.wide))
		else $error("width select not following strap");
endmodule : spm_pin_mux

`default_nettype wire

// file: verif/spm_board.sv
// Board model: strap resistors plus outside drivers of the host and GPIO pins.
// Assumes pad outputs and enables from the pin mux; undriven pins show ext.
`default_nettype none

module spm_board (
	input  wire logic [2:0]  cfg,
	output logic             host_width_strap_pin,
	output logic             atm_strap_pin,
	output logic             pci_strap_pin,
	input  wire logic [31:0] hd_o,
	input  wire logic [31:0] hd_oe,
	input  wire logic [31:0] hd_ext,
	output logic [31:0]      hd_i,
	input  wire logic [15:0] gp_o,
	input  wire logic [15:0] gp_oe,
	input  wire logic [15:0] gp_ext,
	output logic [15:0]      gp_i
);
	timeunit 1ns;
	timeprecision 1ns;
	// Straps are steady levels; cfg only moves between resets or on purpose
	assign host_width_strap_pin = cfg[0];
	assign atm_strap_pin        = cfg[1];
	assign pci_strap_pin        = cfg[2];
	// A released pin shows the outside pattern, never the last driven level
	assign hd_i = (hd_o & hd_oe) | (hd_ext & ~hd_oe);
	assign gp_i = (gp_o & gp_oe) | (gp_ext & ~gp_oe);
endmodule : spm_board

`default_nettype wire

// file: verif/tb_strap_and_pin_function_mux.sv
// Self-checking bench for the pin mux: strap sets, GPIO steering, bus.
// Assumes spm_pin_mux, spm_board and the register map header.
`default_nettype none
`include "spm_map.svh"

module tb_strap_and_pin_function_mux;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, hpi_doe, pci_ad_oe;
	logic cpu_div4_clock_output, cpu_div6_clock_output, serial_port2_ext_clock_input;
	logic host_width_strap_pin, atm_strap_pin, pci_strap_pin, host_port_width_select;
	logic [4:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, rd_d, host_data_bus_i, host_data_bus_o, host_data_bus_oe;
	logic [31:0] hpi_dout, hpi_din, pci_ad_out, pci_ad_in;
	logic [1:0] s_bresp, s_rresp, rd_r, sp1_solo_o, sp1_solo_oe, sp1_solo_out, atm_solo_o;
	logic [1:0] atm_solo_oe, atm_solo_out, pci_solo_o, pci_solo_oe, pci_solo_out;
	logic [3:0] s_wstrb, shared_pin_i, shared_pin_o, shared_pin_oe, sp1_out, sp1_oe;
	logic [3:0] sp1_in, atm_out, atm_oe, atm_in;
	logic [15:0] gpio_pin_i, gpio_pin_o, gpio_pin_oe, gp_ext;
	logic [15:9] pci_gp_out, pci_gp_oe, pci_gp_in;
	logic [2:0] cfg;
	int errors, num_checks;

	assign shared_pin_i = ~shared_pin_o;

	spm_pin_mux u_spm_pin_mux (.clk, .rst_n, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
		.s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
		.s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
		.host_width_strap_pin, .atm_strap_pin, .pci_strap_pin, .host_port_width_select,
		.host_data_bus_i, .host_data_bus_o, .host_data_bus_oe, .hpi_dout, .hpi_doe,
		.hpi_din, .pci_ad_out, .pci_ad_oe, .pci_ad_in, .shared_pin_i, .shared_pin_o,
		.shared_pin_oe, .sp1_out, .sp1_oe, .sp1_in, .atm_out, .atm_oe, .atm_in,
		.sp1_solo_o, .sp1_solo_oe, .sp1_solo_out, .atm_solo_o, .atm_solo_oe,
		.atm_solo_out, .pci_solo_o, .pci_solo_oe, .pci_solo_out, .gpio_pin_i, .gpio_pin_o,
		.gpio_pin_oe, .cpu_div4_clock_output, .cpu_div6_clock_output,
		.serial_port2_ext_clock_input, .pci_gp_out, .pci_gp_oe, .pci_gp_in);

	spm_board u_spm_board (.cfg, .host_width_strap_pin, .atm_strap_pin, .pci_strap_pin,
		.hd_o(host_data_bus_o), .hd_oe(host_data_bus_oe), .hd_ext(32'h5a5a_a5a5),
		.hd_i(host_data_bus_i), .gp_o(gpio_pin_o), .gp_oe(gpio_pin_oe), .gp_ext,
		.gp_i(gpio_pin_i));

	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end

	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	// One bus transfer; read result lands in rd_d and rd_r
	task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		s_awaddr  <= a;
		s_araddr  <= a;
		s_wdata   <= wd;
		s_awvalid <= w;
		s_wvalid  <= w;
		s_bready  <= w;
		s_arvalid <= !w;
		s_rready  <= !w;
		do begin
			@(posedge clk);
			n++;
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
			if (s_arready) s_arvalid <= 1'b0;
			if (n > 40) begin
				errors++;
				summarize();
			end
		end while (!(w ? s_bvalid : s_rvalid));
		rd_d = s_rdata;
		rd_r = w ? s_bresp : s_rresp;
		s_bready <= 1'b0;
		s_rready <= 1'b0;
		@(posedge clk);
	endtask : xfer

	// Straps are set before reset so they are caught at its release
	task automatic rst(input logic [2:0] c);
		cfg   <= c;
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
	endtask : rst

	task automatic t_narrow;
		rst(3'h0);
		chk("width", host_port_width_select, 0);
		chk("hd_oe", host_data_bus_oe, 32'h0000_ffff);
		chk("sh_o", shared_pin_o, 4'h6);
		chk("atm_in", atm_in, 0);
		chk("atm_solo", atm_solo_oe, 0);
		chk("pci_solo", pci_solo_oe, 0);
		chk("pci_in", pci_ad_in, 0);
		chk("sh_oe", shared_pin_oe, 4'hf);
		chk("sp1_in", sp1_in, 4'h9);
		chk("sp1_solo", {sp1_solo_oe, sp1_solo_o}, 4'he);
		chk("hpi_din", hpi_din, 32'h0000_f00d);
		chk("gp1_oe", gpio_pin_oe[1], 1);
		chk("sp2ck", serial_port2_ext_clock_input, 1);
		xfer(1'b0, `SPM_OFF_GP_EN, 0);
		chk("en", rd_d, 0);
		$display("narrow done");
	endtask : t_narrow

	task automatic t_wide_atm;
		rst(3'h3);
		chk("width", host_port_width_select, 1);
		chk("hd_oe", host_data_bus_oe, 32'hffff_ffff);
		chk("hd_o", host_data_bus_o, 32'hcafe_f00d);
		chk("sh_o", shared_pin_o, 4'h9);
		chk("sp1_in", sp1_in, 0);
		chk("sp1_solo", sp1_solo_oe, 0);
		chk("atm_solo", atm_solo_oe, 2'h3);
		chk("pci_solo", pci_solo_oe, 0);
		chk("atm_in", atm_in, 4'h6);
		chk("solo_o", {atm_solo_o, sp1_solo_o}, 4'hc);
		chk("hpi_din", hpi_din, 32'hcafe_f00d);
		cfg <= 3'h0;
		repeat (4) @(posedge clk);
		chk("width", host_port_width_select, 1);
		chk("sh_o", shared_pin_o, 4'h9);
		$display("wide atm done");
	endtask : t_wide_atm

	task automatic t_gpio;
		rst(3'h0);
		xfer(1'b1, `SPM_OFF_GP_EN, 32'h0000_020a);
		chk("bresp", rd_r, `SPM_RESP_OKAY);
		xfer(1'b1, `SPM_OFF_GP_DIR, 32'h0000_0202);
		xfer(1'b1, `SPM_OFF_GP_OUT, 32'h0000_0202);
		repeat (3) @(posedge clk);
		chk("gp_oe", gpio_pin_oe & 16'h020a, 16'h0202);
		chk("gp_o", gpio_pin_o & 16'h0202, 16'h0202);
		xfer(1'b0, `SPM_OFF_GP_IN, 0);
		chk("gp_in", rd_d, 32'h0000_020a);
		xfer(1'b1, `SPM_OFF_GP_DIR, 0);
		repeat (3) @(posedge clk);
		chk("gp_oe", gpio_pin_oe & 16'h020a, 0);
		xfer(1'b1, `SPM_OFF_GP_DIR, 32'h0000_0202);
		xfer(1'b1, `SPM_OFF_GP_EN, 32'h0000_0200);
		cpu_div4_clock_output <= 1'b1;
		repeat (3) @(posedge clk);
		chk("gp1", gpio_pin_o[1], 1);
		cpu_div4_clock_output <= 1'b0;
		repeat (3) @(posedge clk);
		chk("gp1", gpio_pin_o[1], 0);
		xfer(1'b0, 5'h14, 0);
		chk("resp", rd_r, `SPM_RESP_SLVERR);
		$display("gpio done");
	endtask : t_gpio

	task automatic t_pci;
		rst(3'h4);
		pci_ad_oe <= 1'b1;
		xfer(1'b1, `SPM_OFF_GP_EN, 32'h0000_fe00);
		xfer(1'b1, `SPM_OFF_GP_DIR, 32'h0000_fe00);
		repeat (3) @(posedge clk);
		chk("gp_up", gpio_pin_oe[15:9], 0);
		chk("hd_o", host_data_bus_o, 32'h1234_5678);
		chk("hd_oe", host_data_bus_oe, 32'hffff_ffff);
		chk("hpi_din", hpi_din, 0);
		chk("pci_solo", pci_solo_oe, 2'h3);
		chk("pci_so", pci_solo_o, 2'h1);
		chk("pci_in", pci_ad_in, 32'h1234_5678);
		chk("pci_gp_in", pci_gp_in, 7'h2d);
		xfer(1'b0, `SPM_OFF_STRAP, 0);
		chk("strap", rd_d, 32'h0000_0004);
		$display("pci done");
	endtask : t_pci

	initial begin
		rst_n = 0;
		cfg = 0;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, pci_ad_oe} = 0;
		{s_awaddr, s_araddr, s_wdata} = 0;
		s_wstrb = 4'hf;
		hpi_doe = 1;
		hpi_dout = 32'hcafe_f00d;
		pci_ad_out = 32'h1234_5678;
		{sp1_out, sp1_oe, atm_out, atm_oe} = 16'h6f9f;
		{sp1_solo_out, atm_solo_out, pci_solo_out} = 6'h2d;
		{cpu_div4_clock_output, cpu_div6_clock_output} = 2'h3;
		gp_ext = 16'h5b5a;
		pci_gp_out = 7'h55;
		pci_gp_oe = 7'h00;
		t_narrow();
		t_wide_atm();
		t_gpio();
		t_pci();
		summarize();
	end
endmodule : tb_strap_and_pin_function_mux

`default_nettype wire
